/* File: design/lacs_avg_mem.sv */
// Four-entry store of load readings with a registered running sum.
// Assumes writes come one per full step from the main block.
`timescale 1ns/1ps
module lacs_avg_mem (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire logic [lacs_pkg::LOAD_W-1:0] wr_data,
   output logic [lacs_pkg::LOAD_W+1:0] sum
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [lacs_pkg::LOAD_W-1:0] mem [lacs_pkg::FILT_DEPTH];
   wire [lacs_pkg::LOAD_W+1:0] next_sum =
      sum - {2'b00, mem[wr_addr]} + {2'b00, wr_data};

   // Sum tracks replaced entry so no adder tree is needed
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < lacs_pkg::FILT_DEPTH; i++) begin
            mem[i] <= '0;
         end
         sum <= '0;
      end else if (wr_en) begin
         mem[wr_addr] <= wr_data;
         sum <= next_sum;
      end
   end
endmodule : lacs_avg_mem

/* File: design/lacs_core.sv */
// Load-adaptive coil current scaling with stop-on-stall.
// Assumes load_value arrives with a one-cycle fullstep strobe from
// logic on the same clock, and restart requests are one-cycle pulses.
`timescale 1ns/1ps
module lacs_core (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic fullstep_strobe,
   input wire logic [lacs_pkg::LOAD_W-1:0] load_value,
   input wire logic load_filter_en,
   input wire logic step_dir_mode,
   input wire logic [lacs_pkg::VEL_W-1:0] step_interval,
   input wire logic [lacs_pkg::VEL_W-1:0] low_velocity_limit,
   input wire logic [lacs_pkg::VEL_W-1:0] high_velocity_limit,
   input wire logic [lacs_pkg::FIELD_W-1:0] lower_load_threshold,
   input wire logic [lacs_pkg::FIELD_W-1:0] upper_load_offset,
   input wire logic [1:0] current_up_step,
   input wire logic [1:0] current_down_rate,
   input wire logic current_floor_sel,
   input wire logic [lacs_pkg::SCALE_W-1:0] run_current_scale,
   input wire logic stop_on_stall_en,
   input wire logic stall_event_clear,
   input wire logic zero_wait_done,
   output logic [lacs_pkg::LOAD_W-1:0] load_reading,
   output logic load_reading_valid,
   output logic [lacs_pkg::SCALE_W-1:0] present_current_scale,
   output logic stall_stop_event,
   output logic stall_flag,
   output logic ramp_halt,
   output logic force_velocity_zero
);
   // ------------------------------------------------------------
   // Measurement and filter
   // ------------------------------------------------------------
   logic [1:0] step_phase;
   logic [lacs_pkg::LOAD_W+1:0] filt_sum;
   logic pend_filt;
   logic pend_raw;
   logic [lacs_pkg::LOAD_W-1:0] raw_hold;

   lacs_avg_mem u_avg (
      .ref_clk(ref_clk),
      .srst(srst),
      .wr_en(fullstep_strobe),
      .wr_addr(step_phase),
      .wr_data(load_value),
      .sum(filt_sum)
   );

   // Filtered result offered after every fourth full step
   wire filt_done = fullstep_strobe && step_phase == 2'd3;
   wire [lacs_pkg::LOAD_W-1:0] filt_avg =
      filt_sum[lacs_pkg::LOAD_W+1:2]; // Divide by four

   // One reading per full step, or per group of four
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         step_phase <= 2'd0;
         pend_raw <= 1'b0;
         pend_filt <= 1'b0;
         raw_hold <= '0;
      end else begin
         step_phase <= fullstep_strobe ? step_phase + 2'd1 : step_phase;
         pend_raw <= fullstep_strobe && !load_filter_en;
         pend_filt <= filt_done && load_filter_en;
         raw_hold <= fullstep_strobe ? load_value : raw_hold;
      end
   end

   // Sum settles one cycle after the fourth write
   wire new_meas = pend_raw || pend_filt;
   wire [lacs_pkg::LOAD_W-1:0] meas = pend_filt ? filt_avg : raw_hold;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         load_reading <= '0;
         load_reading_valid <= 1'b0;
      end else begin
         load_reading <= new_meas ? meas : load_reading;
         load_reading_valid <= new_meas;
      end
   end

   // ------------------------------------------------------------
   // Velocity window
   // ------------------------------------------------------------
   // Larger step interval means slower motion; low limit unused in
   // step/dir mode since no ramp generator is running
   wire fast_enough = step_dir_mode || step_interval <= low_velocity_limit;
   wire not_too_fast = step_interval >= high_velocity_limit;
   wire in_window = fast_enough && not_too_fast;

   // ------------------------------------------------------------
   // Thresholds and limits
   // ------------------------------------------------------------
   wire [lacs_pkg::LOAD_W:0] low_thr =
      {2'b00, lower_load_threshold, 5'h00};
   wire [lacs_pkg::LOAD_W:0] up_thr =
      {({2'b00, lower_load_threshold} + {2'b00, upper_load_offset}
        + 6'h01), 5'h00};
   wire adapt_on = in_window && lower_load_threshold != 4'h0;
   wire below_low = {1'b0, meas} < low_thr;
   wire at_or_above_up = {1'b0, meas} >= up_thr;

   wire [lacs_pkg::SCALE_W-1:0] floor_val = current_floor_sel ?
      5'(run_current_scale >> 2) : 5'(run_current_scale >> 1);
   wire [lacs_pkg::SCALE_W:0] up_amt = 6'(6'h01 << current_up_step);
   wire [lacs_pkg::SCALE_W:0] raised =
      {1'b0, present_current_scale} + up_amt;
   wire [lacs_pkg::SCALE_W-1:0] ceil_raised =
      raised > {1'b0, run_current_scale} ? run_current_scale :
      raised[lacs_pkg::SCALE_W-1:0];

   logic [5:0] down_need;
   always_comb begin
      case (current_down_rate)
         2'd0: down_need = lacs_pkg::DOWN_CNT_32;
         2'd1: down_need = lacs_pkg::DOWN_CNT_8;
         2'd2: down_need = lacs_pkg::DOWN_CNT_2;
         default: down_need = lacs_pkg::DOWN_CNT_1;
      endcase
   end

   // ------------------------------------------------------------
   // Current scale regulator
   // ------------------------------------------------------------
   logic [5:0] high_cnt;
   logic [lacs_pkg::SCALE_W-1:0] next_scale;
   logic [5:0] next_high_cnt;

   // Outside adaptation the full run current applies
   always_comb begin
      next_scale = present_current_scale;
      next_high_cnt = high_cnt;
      if (!adapt_on) begin
         next_scale = run_current_scale;
         next_high_cnt = 6'h00;
      end else if (new_meas) begin
         if (below_low) begin
            next_scale = ceil_raised;
            next_high_cnt = 6'h00;
         end else if (at_or_above_up) begin
            if (high_cnt + 6'h01 >= down_need) begin
               next_high_cnt = 6'h00;
               next_scale = present_current_scale > floor_val ?
                  present_current_scale - 5'h01 : floor_val;
            end else begin
               next_high_cnt = high_cnt + 6'h01;
            end
         end
         // Not above run current after a reading if run current was lowered
         if (next_scale > run_current_scale) begin
            next_scale = run_current_scale;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         present_current_scale <= lacs_pkg::SCALE_RESET;
         high_cnt <= 6'h00;
      end else begin
         present_current_scale <= next_scale;
         high_cnt <= next_high_cnt;
      end
   end

   // ------------------------------------------------------------
   // Stall stop
   // ------------------------------------------------------------
   wire stall_seen = new_meas && meas == lacs_pkg::STALL_LEVEL;
   wire stall_trip = stall_seen && stop_on_stall_en && in_window;

   // Set wins over clear so a stall during write-back is kept
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stall_stop_event <= 1'b0;
         stall_flag <= 1'b0;
      end else begin
         stall_stop_event <= stall_trip ||
            (stall_stop_event && !stall_event_clear);
         stall_flag <= stall_trip ||
            (stall_flag && !stall_event_clear);
      end
   end

   // Motion resumes only once the ramp's zero wait has run out
   logic resume_wait;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         resume_wait <= 1'b0;
      end else begin
         resume_wait <= stall_trip ? 1'b0 :
            (stall_stop_event && stall_event_clear) ? 1'b1 :
            (zero_wait_done ? 1'b0 : resume_wait);
      end
   end

   assign ramp_halt = stall_stop_event || resume_wait;
   assign force_velocity_zero = stall_stop_event;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_stall_sets_event: assert property (@(posedge ref_clk)
      disable iff (srst)
      stall_trip |=> stall_stop_event && stall_flag && force_velocity_zero)
      else $error("stall did not raise stop event");
   chk_scale_ceiling: assert property (@(posedge ref_clk)
      disable iff (srst)
      $past(new_meas) && $past(adapt_on)
         |-> present_current_scale <= $past(run_current_scale))
      else $error("scale above run current");
   // Release edge left out: the scale still shows its reset value there
   chk_scale_off_run: assert property (@(posedge ref_clk)
      disable iff (srst)
      !srst && !adapt_on
         |=> present_current_scale == $past(run_current_scale))
      else $error("scale not run current outside window");
   chk_scale_hold: assert property (@(posedge ref_clk)
      disable iff (srst)
      adapt_on && !new_meas |=> $stable(present_current_scale))
      else $error("scale changed without measurement");
   chk_zero_stall: assert property (@(posedge ref_clk)
      disable iff (srst)
      new_meas && meas != lacs_pkg::STALL_LEVEL && !stall_stop_event
         && !stall_trip |=> !stall_stop_event)
      else $error("stall event without zero reading");
   chk_window_gate: assert property (@(posedge ref_clk)
      disable iff (srst)
      !in_window && !stall_stop_event |=> !stall_stop_event)
      else $error("stall stop outside velocity window");
   chk_filt_rate: assert property (@(posedge ref_clk)
      disable iff (srst)
      pend_filt |-> $past(step_phase, 1) == 2'd3)
      else $error("filtered reading off group boundary");
   chk_resume_clear: assert property (@(posedge ref_clk)
      disable iff (srst)
      stall_stop_event && stall_event_clear && !stall_trip
         |=> !stall_stop_event ##0 ramp_halt)
      else $error("write-back did not clear event");
   // Expected step rebuilt from the field, not from the adder
   chk_raise_step: assert property (@(posedge ref_clk)
      disable iff (srst)
      adapt_on && new_meas && below_low && raised <= {1'b0, run_current_scale}
         |=> present_current_scale == $past(present_current_scale)
            + (5'h01 << $past(current_up_step)))
      else $error("increment wrong");
endmodule : lacs_core

/* File: design/lacs_pkg.sv */
// Package for the load-adaptive current and stall-stop block.
// Assumes a single 250 MHz system clock; no register bus.
package lacs_pkg;
   localparam int unsigned LOAD_W = 10;
   localparam int unsigned SCALE_W = 5;
   localparam int unsigned VEL_W = 20;
   localparam int unsigned FIELD_W = 4;
   localparam int unsigned FILT_DEPTH = 4;
   localparam int unsigned THR_SHIFT = 5;
   localparam logic [LOAD_W-1:0] STALL_LEVEL = 10'h000;
   localparam logic [SCALE_W-1:0] SCALE_RESET = 5'h1F;
   localparam logic [5:0] DOWN_CNT_32 = 6'h20;
   localparam logic [5:0] DOWN_CNT_8 = 6'h08;
   localparam logic [5:0] DOWN_CNT_2 = 6'h02;
   localparam logic [5:0] DOWN_CNT_1 = 6'h01;
   localparam int unsigned CLK_PERIOD_NS = 4;
endpackage : lacs_pkg

/* File: dv/lacs_core_test.sv */
// Self-checking bench for lacs_core with a ramp model.
// Assumes the 4 ns clock and strobes at least 2 cycles apart.
`timescale 1ns/1ps
module lacs_core_test;
   logic ref_clk = 1'b0, srst = 1'b1, fullstep_strobe = 1'b0;
   logic [9:0] load_value = 10'h000;
   logic load_filter_en = 1'b1, step_dir_mode = 1'b0;
   logic [19:0] step_interval = 20'h00064;
   logic [19:0] low_velocity_limit = 20'h000C8;
   logic [19:0] high_velocity_limit = 20'h00032;
   logic [3:0] lower_load_threshold = 4'h0, upper_load_offset = 4'h1;
   logic [1:0] current_up_step = 2'h0, current_down_rate = 2'h3;
   logic current_floor_sel = 1'b0, stop_on_stall_en = 1'b0;
   logic stall_event_clear = 1'b0, zero_wait_done;
   logic [4:0] run_current_scale = 5'h10;
   logic [9:0] load_reading;
   logic [4:0] present_current_scale;
   logic load_reading_valid, stall_stop_event, stall_flag;
   logic ramp_halt, force_velocity_zero;
   int fail_count = 0, total_checks = 0, i, cnt[4] = '{32, 8, 2, 1};
   always #2 ref_clk = ~ref_clk;
   lacs_core uut (.ref_clk, .srst, .fullstep_strobe, .load_value,
      .load_filter_en, .step_dir_mode, .step_interval, .low_velocity_limit,
      .high_velocity_limit, .lower_load_threshold, .upper_load_offset,
      .current_up_step, .current_down_rate, .current_floor_sel,
      .run_current_scale, .stop_on_stall_en, .stall_event_clear,
      .zero_wait_done, .load_reading, .load_reading_valid,
      .present_current_scale, .stall_stop_event, .stall_flag, .ramp_halt,
      .force_velocity_zero);
   lacs_ramp_model #(.ZW(5)) ramp (.ref_clk, .srst, .ramp_halt,
      .stall_stop_event, .zero_wait_done);
   // ---
   // Compare and drive tasks
   // ---
   task automatic cmp_num(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_num
   task automatic cmp_flag(input logic got, input logic exp);
      cmp_num({9'h000, got}, {9'h000, exp});
   endtask : cmp_flag
   // One full step; returns just after the answer edge N+2
   task automatic step(input logic [9:0] v);
      @(posedge ref_clk);
      fullstep_strobe <= 1'b1;
      load_value <= v;
      @(posedge ref_clk);
      fullstep_strobe <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask : step
   task automatic steps(input int n, input logic [9:0] v);
      repeat (n) step(v);
   endtask : steps
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   // ---
   // Watchdog, far beyond the few hundred cycles needed
   // ---
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end
   // ---
   // Test sequence
   // ---
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      cmp_num(present_current_scale, 10'h010);
      cmp_flag(stall_stop_event, 1'b0);
      cmp_flag(ramp_halt, 1'b0);
      for (i = 0; i < 4; i++) begin
         step(10'h064 * 10'(i + 1));
         cmp_flag(load_reading_valid, i == 3);
      end
      cmp_num(load_reading, 10'h0FA);
      @(posedge ref_clk);
      load_filter_en <= 1'b0;
      lower_load_threshold <= 4'h2;
      step(10'h055);
      cmp_flag(load_reading_valid, 1'b1);
      cmp_num(load_reading, 10'h055);
      $display("test filter done");
      // Thresholds 64 and 128, with boundary readings
      step(10'h080);
      cmp_num(present_current_scale, 10'h00F);
      step(10'h07F);
      cmp_num(present_current_scale, 10'h00F);
      step(10'h040);
      cmp_num(present_current_scale, 10'h00F);
      step(10'h03F);
      cmp_num(present_current_scale, 10'h010);
      steps(12, 10'h3FF);
      cmp_num(present_current_scale, 10'h008);
      cmp_num(load_reading, 10'h3FF);
      @(posedge ref_clk);
      current_floor_sel <= 1'b1;
      for (i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         current_up_step <= 2'(i);
         steps(10, 10'h3FF);
         cmp_num(present_current_scale, 10'h004);
         step(10'h00A);
         cmp_num(present_current_scale, 10'h004 + (10'h001 << i));
      end
      steps(2, 10'h00A);
      cmp_num(present_current_scale, 10'h010);
      for (i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         current_down_rate <= 2'(i);
         step(10'h00A);
         steps(cnt[i] - 1, 10'h3FF);
         cmp_num(present_current_scale, 10'h010);
         step(10'h3FF);
         cmp_num(present_current_scale, 10'h00F);
      end
      @(posedge ref_clk);
      lower_load_threshold <= 4'h0;
      step(10'h3FF);
      cmp_num(present_current_scale, 10'h010);
      $display("test adaptation done");
      // Window gates both adaptation and stall stop; enable gates stall stop
      @(posedge ref_clk);
      lower_load_threshold <= 4'h2;
      stop_on_stall_en <= 1'b1;
      step_interval <= 20'h0012C;
      steps(3, 10'h3FF);
      cmp_num(present_current_scale, 10'h010);
      step(10'h000);
      cmp_flag(stall_stop_event, 1'b0);
      @(posedge ref_clk);
      step_interval <= 20'h00028;
      steps(3, 10'h3FF);
      cmp_num(present_current_scale, 10'h010);
      step(10'h000);
      cmp_flag(stall_stop_event, 1'b0);
      @(posedge ref_clk);
      step_interval <= 20'h00064;
      stop_on_stall_en <= 1'b0;
      step(10'h000);
      cmp_flag(stall_stop_event, 1'b0);
      @(posedge ref_clk);
      stop_on_stall_en <= 1'b1;
      step_dir_mode <= 1'b1;
      step_interval <= 20'h0012C;
      step(10'h000);
      cmp_flag(stall_stop_event, 1'b1);
      cmp_flag(stall_flag, 1'b1);
      cmp_flag(ramp_halt, 1'b1);
      cmp_flag(force_velocity_zero, 1'b1);
      @(posedge ref_clk);
      stall_event_clear <= 1'b1;
      @(posedge ref_clk);
      stall_event_clear <= 1'b0;
      @(posedge ref_clk);
      #1;
      cmp_flag(stall_stop_event, 1'b0);
      cmp_flag(stall_flag, 1'b0);
      cmp_flag(ramp_halt, 1'b1);
      for (i = 0; i < 20 && ramp_halt !== 1'b0; i++) @(posedge ref_clk);
      #1;
      cmp_flag(ramp_halt, 1'b0);
      $display("test stall done");
      give_verdict();
   end
endmodule : lacs_core_test

/* File: dv/lacs_ramp_model.sv */
// Ramp generator stand-in: times the zero wait after a stall stop.
// Assumes ramp_halt and stall_stop_event come from lacs_core.
`timescale 1ns/1ps
module lacs_ramp_model #(
   parameter int ZW = 5
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ramp_halt,
   input wire logic stall_stop_event,
   output logic zero_wait_done
);
   int cnt;
   initial zero_wait_done = 1'b0;
   // ---
   // Zero wait runs only once the event is cleared
   // ---
   always @(posedge ref_clk) begin
      zero_wait_done <= 1'b0;
      if (srst || !ramp_halt || stall_stop_event) begin
         cnt <= 0;
      end else if (cnt == ZW) begin
         zero_wait_done <= 1'b1; // One-cycle pulse
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : lacs_ramp_model
